/* pkg/rxq_pkg.sv */
// constants and types for the receive queue record builder
// Contract
// [RQ1] status word at 0, count at 2
// [RQ2] frame bytes follow from offset 4
// [RQ3] keep CRC unless stripping is enabled
// [RQ4] count bits 10-0, max 1916
// [RQ5] valid bit set once frame complete
// [RQ6] valid bit clear when none pending
// [RQ7] bit 7 marks broadcast destination
// [RQ8] bit 6 marks multicast, broadcast included
// [RQ9] bit 5 marks unicast destination
// [RQ10] bit 3 set when length/type over 1500
// [RQ11] host ignores bit 3 on runts
// [RQ12] bit 2 set above 1518 bytes
// [RQ13] oversize only flags, never truncates; code drops frames over 1518 bytes unless pass-bad, and always drops frames past 1916 stored bytes
// [RQ14] bit 1 marks collision or runt
// [RQ15] bit 0 marks bad frame check sequence
// [RQ16] bad frames kept only with pass-bad
// [RQ17] status register mirrors head frame
// [RQ18] 4KB of packet memory
// [RQ19] reserved bits read as zero
// [RQ20] first byte low, second byte high
package rxq_pkg;

    // ****************************************
    // memory geometry
    // ****************************************
    localparam int                MEM_WORDS    = 2048;
    localparam int                AW           = 11;
    localparam int                PTR_W        = 12;
    localparam int                CNT_W        = 11;
    localparam int                FR_W         = 8;
    localparam logic [PTR_W-1:0]  MEM_SPAN     = 12'h800;
    localparam logic [PTR_W-1:0]  HDR_WORDS    = 12'h002;
    localparam logic [PTR_W-1:0]  PTR_ONE      = 12'h001;
    localparam logic [AW-1:0]     OFF_STATUS_W = 11'h000;
    localparam logic [AW-1:0]     OFF_COUNT_W  = 11'h001;
    localparam logic [AW-1:0]     OFF_DATA_W   = 11'h002;

    // ****************************************
    // frame lengths and field positions
    // ****************************************
    localparam logic [CNT_W-1:0]  MAX_BYTES    = 11'h77C;
    localparam logic [CNT_W-1:0]  MAX_LEN      = 11'h5EE;
    localparam logic [CNT_W-1:0]  MIN_FRAME    = 11'h040;
    localparam logic [CNT_W-1:0]  CRC_BYTES    = 11'h004;
    localparam logic [CNT_W-1:0]  CNT_MAX      = 11'h7FF;
    localparam logic [CNT_W-1:0]  CNT_ONE      = 11'h001;
    localparam logic [CNT_W-1:0]  DA_LAST      = 11'h005;
    localparam logic [CNT_W-1:0]  LT_HI        = 11'h00C;
    localparam logic [CNT_W-1:0]  LT_LO        = 11'h00D;
    localparam logic [15:0]       TYPE_MIN     = 16'h05DC;
    localparam logic [7:0]        BCAST_BYTE   = 8'hFF;
    localparam int                HOLD_DEPTH   = 4;
    localparam logic [2:0]        HOLD_FULL    = 3'h4;

    // ****************************************
    // status word bits
    // ****************************************
    localparam int                ST_VALID     = 15;
    localparam int                ST_BCAST     = 7;
    localparam int                ST_MCAST     = 6;
    localparam int                ST_UCAST     = 5;
    localparam int                ST_TYPE      = 3;
    localparam int                ST_LONG      = 2;
    localparam int                ST_RUNT      = 1;
    localparam int                ST_CRC       = 0;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0]        REG_CTRL     = 8'h00;
    localparam logic [7:0]        REG_STATUS   = 8'h04;
    localparam logic [7:0]        REG_COUNT    = 8'h08;
    localparam logic [7:0]        REG_DATA     = 8'h0C;
    localparam logic [7:0]        REG_RELEASE  = 8'h10;
    localparam logic [7:0]        REG_FRAMES   = 8'h14;
    localparam logic [7:0]        REG_DROPS    = 8'h18;
    localparam int                CTRL_STRIP   = 0;
    localparam int                CTRL_PASS    = 1;

    typedef enum logic [2:0] {W_IDLE, W_DATA, W_TAIL, W_STAT, W_CNT} wr_state_t;

endpackage

/* verification/host_reader.sv */
// host-side model that reads frame records out of the receive queue
`timescale 1ns/10ps
module host_reader
    import rxq_pkg::*;
(
    // clock
    input  wire logic        sys_clk_i,
    // register port
    input  wire logic [31:0] reg_rdata_i,
    output logic [7:0]       reg_addr_o,
    output logic [31:0]      reg_wdata_o,
    output logic             reg_wr_o,
    output logic             reg_rd_o
);
    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 32'h0000_0000;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_o    <= 1'b0;
        reg_wdata_o <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_o   <= 1'b0;
        #1 d = reg_rdata_i;
        // type bit carries no meaning on runts
        if (a == REG_STATUS && d[ST_RUNT] === 1'b1) d[ST_TYPE] = 1'b0;
    endtask
endmodule

/* verification/test_rx_queue_frame_descriptor.sv */
// self-checking bench for the receive queue record builder
`timescale 1ns/10ps
module test_rx_queue_frame_descriptor;
    import rxq_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        rx_valid_i = 1'b0, rx_sof_i = 1'b0, rx_eof_i = 1'b0;
    logic        rx_crc_err_i = 1'b0, rx_collision_i = 1'b0;
    logic [7:0]  rx_data_i = 8'h00, reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, rd_d, seed = 32'h8091_ad87;
    logic        reg_wr_i, reg_rd_i, frame_pending_o, rx_drop_o;
    int          n_mismatch = 0, cmp_count = 0, cycles = 0, n_drop = 0;

    always #2.5 sys_clk_i = ~sys_clk_i;

    rx_queue_frame_descriptor DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .rx_valid_i(rx_valid_i),
        .rx_data_i(rx_data_i), .rx_sof_i(rx_sof_i), .rx_eof_i(rx_eof_i), .rx_crc_err_i(rx_crc_err_i),
        .rx_collision_i(rx_collision_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .frame_pending_o(frame_pending_o), .rx_drop_o(rx_drop_o));
    host_reader host (.sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // cls 0 broadcast, 1 multicast, 2 unicast
    task automatic run(input int cls, input logic [15:0] typ, input int len, input logic crc, input logic col,
                       input logic [1:0] ctrl);
        logic [7:0]  b, b0, b1;
        logic [15:0] st;
        logic        runt, lng, keep, pend, drp;
        host.wr(REG_CTRL, {30'h0, ctrl});
        for (int i = 0; i < len; i++) begin
            seed = lfsr(seed);
            b = seed[7:0];
            if (i == 0) b = (cls == 0) ? 8'hFF : {cls == 1 ? 1'b0 : b[7], b[6:1], cls == 1};
            if (i > 0 && i < 6 && cls == 0) b = 8'hFF;
            if (i == 12) b = typ[15:8];
            if (i == 13) b = typ[7:0];
            if (i == 0) b0 = b;
            if (i == 1) b1 = b;
            @(posedge sys_clk_i);
            rx_valid_i     <= 1'b1;
            rx_data_i      <= b;
            rx_sof_i       <= (i == 0);
            rx_eof_i       <= (i == len - 1);
            rx_crc_err_i   <= crc && (i == len - 1);
            rx_collision_i <= col && (i == 5);
        end
        @(posedge sys_clk_i);
        rx_valid_i     <= 1'b0;
        rx_data_i      <= ~b;
        rx_sof_i       <= 1'b0;
        rx_eof_i       <= 1'b0;
        rx_crc_err_i   <= 1'b0;
        rx_collision_i <= 1'b0;
        #1 chk("pending in frame", frame_pending_o, 0);
        runt = (len < 64) || col;
        lng  = len > 1518;
        keep = !(runt || lng || crc) || ctrl[1];
        st = {1'b1, 7'h0, cls == 0, cls != 2, cls == 2, 1'b0, typ > 16'h05DC && !runt, lng, runt, crc};
        pend = 1'b0;
        drp = 1'b0;
        // the drop pulse stands in the cycle after the last byte, or one cycle later for a tail-word drop, so look from here on
        repeat (6) begin
            pend |= frame_pending_o;
            drp |= rx_drop_o;
            @(posedge sys_clk_i);
            #1;
        end
        chk("pending", pend, keep);
        chk("drop", drp, !keep);
        if (!keep) n_drop++;
        if (keep) begin
            host.rd(REG_STATUS, rd_d);
            chk("status", rd_d, {16'h0, st});
            host.rd(REG_COUNT, rd_d);
            chk("count", rd_d, ctrl[0] ? 32'(len - 4) : 32'(len));
            host.rd(REG_DATA, rd_d);
            chk("first word", rd_d, {16'h0, b1, b0});
            host.rd(REG_FRAMES, rd_d);
            chk("frames", rd_d, 1);
            host.wr(REG_RELEASE, 32'h0000_0001);
            @(posedge sys_clk_i);
            #1 chk("pending after release", frame_pending_o, 0);
            host.rd(REG_STATUS, rd_d);
            chk("empty status", rd_d, 0);
        end
    endtask

    task automatic stop_test;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            stop_test();
        end
    end

    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        host.rd(REG_CTRL, rd_d);
        chk("ctrl reset", rd_d, 0);
        host.rd(8'hFC, rd_d);
        chk("unmapped", rd_d, 0);
        run(2, 16'h0800, 64, 0, 0, 2'b00);
        run(0, 16'h0040, 65, 0, 0, 2'b01);
        run(1, 16'h0800, 70, 1, 0, 2'b00);
        run(1, 16'h0800, 70, 1, 0, 2'b10);
        run(2, 16'h0800, 40, 0, 0, 2'b10);
        run(2, 16'h0800, 64, 0, 1, 2'b00);
        run(0, 16'h05DC, 1520, 0, 0, 2'b10);
        run(2, 16'h05DD, 1520, 0, 0, 2'b00);
        repeat (6) begin
            seed = lfsr(seed);
            run(int'(seed[3:0]) % 3, seed[31:16], 64 + int'(seed[10:4]), 1'b0, 1'b0, seed[12:11]);
        end
        host.rd(REG_DROPS, rd_d);
        chk("drops", rd_d, n_drop);
        stop_test();
    end
endmodule

/* verilog/crc_tail_hold.sv */
// four-byte hold that withholds the trailing frame check sequence
`timescale 1ns/10ps
module crc_tail_hold
    import rxq_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    // control
    input  wire logic        clear_i,
    input  wire logic        strip_i,
    // byte in
    input  wire logic        in_valid_i,
    input  wire logic [7:0]  in_byte_i,
    // byte out
    output logic             out_valid_o,
    output logic [7:0]       out_byte_o
);

    logic [7:0] stage_q [HOLD_DEPTH];
    logic [2:0] fill_q;
    logic [2:0] fill_b;

    assign fill_b = clear_i ? 3'h0 : fill_q;

    // the last four bytes are never released when stripping, see [RQ3]
    assign out_valid_o = in_valid_i && (!strip_i || fill_b == HOLD_FULL);
    assign out_byte_o  = strip_i ? stage_q[HOLD_DEPTH-1] : in_byte_i;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fill_q <= 3'h0;
        end else if (in_valid_i) begin
            fill_q <= (fill_b == HOLD_FULL) ? HOLD_FULL : fill_b + 3'h1;
        end else begin
            fill_q <= fill_b;
        end
    end

    genvar k;
    generate
        for (k = 0; k < HOLD_DEPTH; k++) begin : g_stage
            always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    stage_q[k] <= 8'h00;
                end else if (in_valid_i) begin
                    stage_q[k] <= (k == 0) ? in_byte_i : stage_q[(k == 0) ? 0 : k-1];
                end
            end
        end
    endgenerate

endmodule

/* verilog/dest_classify.sv */
// destination class and length/type decode of an incoming frame
`timescale 1ns/10ps
module dest_classify
    import rxq_pkg::*;
(
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             rst_b_i,
    // raw byte stream
    input  wire logic             byte_valid_i,
    input  wire logic [7:0]       byte_i,
    input  wire logic [CNT_W-1:0] idx_i,
    // flags
    output logic                  bcast_o,
    output logic                  mcast_o,
    output logic                  ucast_o,
    output logic                  type_o
);

    logic [7:0] lt_hi_byte_q;

    assign ucast_o = !mcast_o; // see [RQ9]

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bcast_o <= 1'b0;
            mcast_o <= 1'b0;
        end else if (byte_valid_i && idx_i == '0) begin
            bcast_o <= (byte_i == BCAST_BYTE);
            mcast_o <= byte_i[0]; // group bit, also set by broadcast, see [RQ8]
        end else if (byte_valid_i && idx_i <= DA_LAST) begin
            bcast_o <= bcast_o && (byte_i == BCAST_BYTE); // see [RQ7]
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lt_hi_byte_q <= 8'h00;
            type_o       <= 1'b0;
        end else if (byte_valid_i) begin
            if (idx_i == '0) begin
                type_o <= 1'b0;
            end
            if (idx_i == LT_HI) begin
                lt_hi_byte_q <= byte_i;
            end
            if (idx_i == LT_LO) begin
                type_o <= ({lt_hi_byte_q, byte_i} > TYPE_MIN); // see [RQ10]
            end
        end
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    type_field_a: assert property (byte_valid_i && idx_i == LT_LO |=> // see [RQ10]
        type_o == ({lt_hi_byte_q, $past(byte_i)} > TYPE_MIN))
        else $error("length/type flag wrong");

endmodule

/* verilog/rx_queue_frame_descriptor.sv */
// receive queue: builds frame records in packet memory and serves them to the host
`timescale 1ns/10ps
module rx_queue_frame_descriptor
    import rxq_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    // mac receive stream
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_sof_i,
    input  wire logic        rx_eof_i,
    input  wire logic        rx_crc_err_i,
    input  wire logic        rx_collision_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [31:0]      reg_rdata_o,
    // status
    output logic             frame_pending_o,
    output logic             rx_drop_o
);

    // ****************************************
    // declarations
    // ****************************************
    wr_state_t        st_q;
    logic [PTR_W-1:0] base_q;
    logic [PTR_W-1:0] wr_q;
    logic [PTR_W-1:0] tail_q;
    logic [PTR_W-1:0] head_q;
    logic [CNT_W-1:0] raw_q;
    logic [CNT_W-1:0] dcnt_q;
    logic [CNT_W-1:0] tot_q;
    logic [CNT_W-1:0] roff_q;
    logic [FR_W-1:0]  frames_q;
    logic [15:0]      drops_q;
    logic [7:0]       low_q;
    logic             ph_q;
    logic             coll_q;
    logic             ovr_q;
    logic             crc_q;
    logic             long_q;
    logic             runt_q;
    logic             strip_q;
    logic             pass_q;
    logic             fstrip_q;
    logic [15:0]      mem [MEM_WORDS]; // 4KB packet memory, see [RQ18]

    logic             take_sof;
    logic             byte_in;
    logic             eof_in;
    logic [CNT_W-1:0] idx;
    logic [CNT_W-1:0] total;
    logic [CNT_W-1:0] dc_b;
    logic             ph_b;
    logic             ovr_b;
    logic             space_ok;
    logic             hb_valid;
    logic [7:0]       hb_byte;
    logic             byte_ok;
    logic             ovr_n;
    logic             bad_n;
    logic             drop_n;
    logic             ph_n;
    logic             cls_b;
    logic             cls_m;
    logic             cls_u;
    logic             cls_t;
    logic             mem_we;
    logic [AW-1:0]    mem_addr;
    logic [15:0]      mem_wdata;
    logic [15:0]      stat_w;
    logic             commit;
    logic             release_n;
    logic [CNT_W-1:0] head_cnt;
    logic [PTR_W-1:0] rel_words;
    logic [FR_W-1:0]  frames_n;
    logic [AW-1:0]    head_a;

    // ****************************************
    // byte stream front end
    // ****************************************
    assign take_sof = (st_q == W_IDLE) && rx_sof_i && rx_valid_i;
    assign byte_in  = rx_valid_i && (take_sof || st_q == W_DATA);
    assign eof_in   = byte_in && rx_eof_i;
    assign idx      = take_sof ? '0 : raw_q;
    assign total    = (idx == CNT_MAX) ? CNT_MAX : idx + CNT_ONE;
    assign dc_b     = take_sof ? '0 : dcnt_q;
    assign ph_b     = take_sof ? 1'b0 : ph_q;
    assign ovr_b    = take_sof ? 1'b0 : ovr_q;
    assign space_ok = PTR_W'(wr_q - head_q) < MEM_SPAN;

    crc_tail_hold u_hold (
        .sys_clk_i   (sys_clk_i),
        .rst_b_i     (rst_b_i),
        .clear_i     (take_sof),
        .strip_i     (take_sof ? strip_q : fstrip_q),
        .in_valid_i  (byte_in),
        .in_byte_i   (rx_data_i),
        .out_valid_o (hb_valid),
        .out_byte_o  (hb_byte)
    );

    dest_classify u_cls (
        .sys_clk_i    (sys_clk_i),
        .rst_b_i      (rst_b_i),
        .byte_valid_i (byte_in),
        .byte_i       (rx_data_i),
        .idx_i        (idx),
        .bcast_o      (cls_b),
        .mcast_o      (cls_m),
        .ucast_o      (cls_u),
        .type_o       (cls_t)
    );

    // length is never cut: a frame past MAX_BYTES or past free memory is dropped whole, see [RQ13]
    assign byte_ok = hb_valid && !ovr_b && dc_b != MAX_BYTES && space_ok; // see [RQ4]
    assign ovr_n   = ovr_b || (hb_valid && !byte_ok);
    assign bad_n   = (total > MAX_LEN) || coll_q || rx_collision_i || (total < MIN_FRAME) || rx_crc_err_i;
    assign drop_n  = ovr_n || (bad_n && !pass_q); // see [RQ16]
    assign ph_n    = ph_b ^ byte_ok;

    // ****************************************
    // record writer
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= W_IDLE;
        end else begin
            case (st_q)
                W_IDLE, W_DATA: begin
                    if (eof_in) begin
                        st_q <= drop_n ? W_IDLE : (ph_n ? W_TAIL : W_STAT);
                    end else if (take_sof) begin
                        st_q <= W_DATA;
                    end
                end
                W_TAIL:  st_q <= space_ok ? W_STAT : W_IDLE;
                W_STAT:  st_q <= W_CNT;
                W_CNT:   st_q <= W_IDLE;
                default: st_q <= W_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            raw_q    <= '0;
            fstrip_q <= 1'b0;
            coll_q   <= 1'b0;
        end else if (byte_in) begin
            raw_q  <= total;
            coll_q <= (take_sof ? 1'b0 : coll_q) || rx_collision_i;
            if (take_sof) begin
                fstrip_q <= strip_q;
            end
        end
    end

    // frame bytes pair into words, first byte in the low half, see [RQ20]
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dcnt_q <= '0;
            ph_q   <= 1'b0;
            low_q  <= 8'h00;
            ovr_q  <= 1'b0;
        end else if (byte_in) begin
            dcnt_q <= dc_b + (byte_ok ? CNT_ONE : '0);
            ph_q   <= ph_n;
            ovr_q  <= ovr_n;
            if (byte_ok && !ph_b) begin
                low_q <= hb_byte;
            end
        end else if (st_q == W_STAT) begin
            ph_q <= 1'b0;
        end
    end

    // flags captured at the frame's last byte
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tot_q  <= '0;
            long_q <= 1'b0;
            runt_q <= 1'b0;
            crc_q  <= 1'b0;
        end else if (eof_in) begin
            tot_q  <= total;
            long_q <= total > MAX_LEN; // see [RQ12]
            runt_q <= coll_q || rx_collision_i || total < MIN_FRAME; // see [RQ14]
            crc_q  <= rx_crc_err_i; // see [RQ15]
        end
    end

    // data words start right after the two header words, see [RQ2]
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            base_q <= '0;
            wr_q   <= HDR_WORDS;
            tail_q <= '0;
        end else begin
            if (take_sof) begin
                base_q <= tail_q;
                wr_q   <= tail_q + HDR_WORDS;
            end else if (mem_we && (st_q == W_DATA || st_q == W_TAIL)) begin
                wr_q <= wr_q + PTR_ONE;
            end
            if (commit) begin
                tail_q <= wr_q;
            end
        end
    end

    always_comb begin
        stat_w            = '0; // reserved bits stay zero, see [RQ19]
        stat_w[ST_VALID]  = 1'b1;
        stat_w[ST_BCAST]  = cls_b;
        stat_w[ST_MCAST]  = cls_m;
        stat_w[ST_UCAST]  = cls_u;
        stat_w[ST_TYPE]   = cls_t;
        stat_w[ST_LONG]   = long_q;
        stat_w[ST_RUNT]   = runt_q;
        stat_w[ST_CRC]    = crc_q;
    end

    // header is written last so a half-built record never looks valid, see [RQ5]
    always_comb begin
        mem_we    = 1'b0;
        mem_addr  = wr_q[AW-1:0];
        mem_wdata = {hb_byte, low_q};
        case (st_q)
            W_IDLE, W_DATA: mem_we = byte_ok && ph_b;
            W_TAIL: begin
                mem_we    = space_ok;
                mem_wdata = {8'h00, low_q};
            end
            W_STAT: begin
                mem_we    = 1'b1;
                mem_addr  = base_q[AW-1:0] + OFF_STATUS_W; // see [RQ1]
                mem_wdata = stat_w;
            end
            W_CNT: begin
                mem_we    = 1'b1;
                mem_addr  = base_q[AW-1:0] + OFF_COUNT_W; // see [RQ1]
                mem_wdata = {{(16-CNT_W){1'b0}}, dcnt_q}; // see [RQ4]
            end
            default: mem_we = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    // ****************************************
    // host side of the queue
    // ****************************************
    assign commit    = (st_q == W_CNT);
    assign release_n = reg_wr_i && reg_addr_i == REG_RELEASE && frame_pending_o;
    assign head_a    = head_q[AW-1:0];
    assign head_cnt  = mem[head_a + OFF_COUNT_W][CNT_W-1:0];
    assign rel_words = HDR_WORDS + PTR_W'(({1'b0, head_cnt} + PTR_ONE) >> 1);
    assign frames_n  = frames_q + FR_W'(commit) - FR_W'(release_n);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strip_q <= 1'b0;
            pass_q  <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
            strip_q <= reg_wdata_i[CTRL_STRIP];
            pass_q  <= reg_wdata_i[CTRL_PASS];
        end
    end

    // a commit and a release in one cycle cancel, nothing is lost
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frames_q        <= '0;
            frame_pending_o <= 1'b0;
            head_q          <= '0;
            roff_q          <= '0;
        end else begin
            frames_q        <= frames_n;
            frame_pending_o <= frames_n != '0; // see [RQ6]
            if (release_n) begin
                head_q <= head_q + rel_words;
                roff_q <= '0;
            end else if (reg_rd_i && reg_addr_i == REG_DATA && frame_pending_o) begin
                roff_q <= roff_q + CNT_ONE;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            drops_q   <= '0;
            rx_drop_o <= 1'b0;
        end else begin
            rx_drop_o <= (eof_in && drop_n) || (st_q == W_TAIL && !space_ok);
            if (rx_drop_o && drops_q != 16'hFFFF) begin
                drops_q <= drops_q + 16'h0001;
            end
        end
    end

    // status reads mirror the record at the head of the queue, see [RQ17]
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (!reg_rd_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            case (reg_addr_i)
                REG_CTRL:   reg_rdata_o <= {30'h0000_0000, pass_q, strip_q};
                REG_STATUS: reg_rdata_o <= frame_pending_o ? {16'h0000, mem[head_a + OFF_STATUS_W]} : '0;
                REG_COUNT:  reg_rdata_o <= frame_pending_o ? {16'h0000, mem[head_a + OFF_COUNT_W]} : '0;
                REG_DATA:   reg_rdata_o <= frame_pending_o ?
                                {16'h0000, mem[head_a + OFF_DATA_W + roff_q]} : '0;
                REG_FRAMES: reg_rdata_o <= {24'h00_0000, frames_q};
                REG_DROPS:  reg_rdata_o <= {16'h0000, drops_q};
                default:    reg_rdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    hdr_status_a: assert property (st_q == W_STAT |-> // see [RQ1]
        mem_we && mem_addr == base_q[AW-1:0] && mem_wdata[ST_VALID])
        else $error("status word not at record start");

    data_start_a: assert property (take_sof |=> wr_q == base_q + HDR_WORDS) // see [RQ2]
        else $error("data area not after header");

    strip_len_a: assert property (eof_in && (take_sof ? strip_q : fstrip_q) && !ovr_n && !drop_n && // see [RQ3]
        total >= CRC_BYTES |=>
        dcnt_q + CRC_BYTES == tot_q)
        else $error("stripped length wrong");

    count_word_a: assert property (st_q == W_CNT |-> // see [RQ4]
        mem_wdata[15:CNT_W] == '0 && mem_wdata[CNT_W-1:0] == dcnt_q && dcnt_q <= MAX_BYTES)
        else $error("count word malformed");

    empty_status_a: assert property (reg_rd_i && reg_addr_i == REG_STATUS && !frame_pending_o |=> // see [RQ6]
        reg_rdata_o == '0)
        else $error("status shows valid with queue empty");

    dest_class_a: assert property (st_q == W_STAT |-> // see [RQ8]
        (!mem_wdata[ST_BCAST] || mem_wdata[ST_MCAST]) && mem_wdata[ST_UCAST] != mem_wdata[ST_MCAST])
        else $error("destination flags inconsistent");

    long_flag_a: assert property (st_q == W_STAT |-> mem_wdata[ST_LONG] == (tot_q > MAX_LEN)) // see [RQ12]
        else $error("oversize flag wrong");

    bad_drop_a: assert property (eof_in && rx_crc_err_i && !pass_q |=> st_q == W_IDLE) // see [RQ16]
        else $error("bad frame not dropped");

    commit_cnt_a: assert property (commit && !release_n |=> // see [RQ5]
        frames_q == $past(frames_q) + 1'b1 && frame_pending_o)
        else $error("completed frame not counted");

endmodule
